// [msbr_top.sv]
// What this block does
// - alarm mic source priority defaults to zero, range zero to ninety-nine.
// - same mic offered as general source, priority two hundred to 299.
// - normally-closed contact idles closed, triggers when it opens.
// - normally-open contact idles open, triggers when it closes.
// - normal NC relay rests closed, opens when its function activates.
// - inverse mode swaps relay rest state, NC relay rests open.
// - up to five extensions accepted, twenty buttons each.
// - latched mode keeps mic active for latch time after one press.
// - any mic activation limited to sixty seconds; latch time capped.
// - press chime pulses on talk press when enabled.
// - release chime pulses after talk release when enabled.
// - aux inputs disabled until typed; main mic enabled by default.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module msbr_top
    import msbr_pkg::*;
#(
    parameter int NCONT = 8,                     // contact inputs
    parameter int NRLY  = 8,                     // relay outputs
    parameter int NEXT  = MSBR_MAX_EXT,          // max extensions
    parameter int NBTN  = MSBR_BTN_PER_EXT,      // buttons per extension
    parameter int CYC_PER_S = MSBR_CLK_HZ        // clock cycles per second
) (
    input  wire logic              ref_clk,      // 20 MHz clock
    input  wire logic              resetn,       // async reset, low
    input  wire logic [3:0]        addr,         // register index
    input  wire logic [15:0]       wdata,        // write data
    input  wire logic              wr,           // write strobe
    input  wire logic              rd,           // read strobe
    output logic      [15:0]       rdata,        // read data, next cycle
    input  wire logic              ptt_pin,      // talk button, high pressed
    input  wire logic [NCONT-1:0]  contact_pin,  // contacts, high closed
    input  wire logic [NEXT*NBTN-1:0] ext_btn_pin, // extension buttons
    output logic [NRLY-1:0]        relay_close,  // high closes relay
    output logic                   mic_alarm_on, // alarm source active
    output logic                   mic_gen_on,   // general source active
    output logic [8:0]             mic_prio,     // priority of live source
    output logic [NCONT-1:0]       contact_evt,  // contact function active
    output logic [NEXT*NBTN-1:0]   ext_btn_evt,  // bound extension buttons
    output logic                   chime_start,  // press chime pulse
    output logic                   chime_end,    // release chime pulse
    output logic                   aux_mic_en,   // aux mic input enabled
    output logic [3:0]             aux_line_en,  // aux line inputs enabled
    output logic                   main_mic_en   // main mic enabled
);
    localparam int NB = NEXT * NBTN;
    localparam int W  = 1 + NCONT + NB;
    localparam int TW = $clog2(MSBR_MAX_TALK_S * CYC_PER_S + 1);
    localparam logic [TW-1:0] MAX_TALK_CYC =
        TW'(MSBR_MAX_TALK_S * CYC_PER_S);

    typedef enum logic [1:0] {MSBR_IDLE, MSBR_HELD, MSBR_LATCH} msbr_st_e;

    logic [15:0]      ctrl_reg;
    logic [5:0]       latch_reg;
    logic [NCONT-1:0] incfg_reg;     // 1 = normally closed
    logic [NRLY-1:0]  rlytype_reg;   // 1 = NC relay
    logic [NRLY-1:0]  rlyinv_reg;    // 1 = inverse mode
    logic [NRLY-1:0]  rlydrv_reg;    // function drive per relay
    logic [6:0]       prio_a_reg;
    logic [6:0]       prio_g_reg;
    logic [2:0]       extsel_reg;
    logic [15:0]      rdata_next;
    msbr_st_e         st_reg;
    logic [TW-1:0]    tmr_reg;
    logic             ptt_q_reg;
    logic             talk;
    logic [2:0]       ext_cnt;
    logic             ptt_s;
    logic [NCONT-1:0] cont_s;
    logic [NB-1:0]    btn_s;

    // talk, contact and button pins come from outside the clock domain
    msbr_sync_if #(.W(W)) sif ();
    assign sif.raw = {ext_btn_pin, contact_pin, ptt_pin};
    msbr_sync #(.W(W)) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .bus     (sif)
    );
    assign ptt_s  = sif.sync[0];
    assign cont_s = sif.sync[NCONT:1];
    assign btn_s  = sif.sync[W-1:NCONT+1];

    // cap a requested value to a bound; whole word compared so that
    // high bits cannot wrap a large request under the cap
    function automatic logic [5:0] msbr_cap(input logic [15:0] v,
                                            input logic [5:0]  mx);
        msbr_cap = (v > 16'(mx)) ? mx : v[5:0];
    endfunction : msbr_cap

    // register writes
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg    <= MSBR_CTRL_RST;
            latch_reg   <= MSBR_LATCH_RST;
            incfg_reg   <= '0;
            rlytype_reg <= '0;
            rlyinv_reg  <= '0;
            rlydrv_reg  <= '0;
            prio_a_reg  <= MSBR_PRIO_ALARM_RST;
            prio_g_reg  <= MSBR_PRIO_GEN_RST[6:0];
            extsel_reg  <= '0;
        end
        else if (wr)
        begin
            case (addr)
                MSBR_OFS_CTRL:   ctrl_reg <= wdata;
                // latch time in seconds, never above the talk limit
                MSBR_OFS_LATCH:  latch_reg <= msbr_cap(wdata,
                                     6'(MSBR_MAX_TALK_S));
                MSBR_OFS_INCFG:  incfg_reg <= wdata[NCONT-1:0];
                MSBR_OFS_RLYCFG:
                begin
                    rlytype_reg <= wdata[NRLY-1:0];
                    rlyinv_reg  <= wdata[NRLY+7:8];
                end
                MSBR_OFS_RLYDRV: rlydrv_reg <= wdata[NRLY-1:0];
                // priorities clamp to 0..99 within their class
                MSBR_OFS_PRIO:
                begin
                    prio_a_reg <= (wdata[6:0] > 7'(MSBR_ALARM_MAX)) ?
                        7'(MSBR_ALARM_MAX) : wdata[6:0];
                    prio_g_reg <= (wdata[14:8] > 7'(MSBR_ALARM_MAX)) ?
                        7'(MSBR_ALARM_MAX) : wdata[14:8];
                end
                // picks which extension the button word shows
                MSBR_OFS_EXTSEL: extsel_reg <= wdata[2:0];
                default: ;
            endcase
        end
    end

    // extension count capped at five
    assign ext_cnt = (ctrl_reg[MSBR_CTRL_EXTLO+:3] > 3'(NEXT)) ?
                     3'(NEXT) : ctrl_reg[MSBR_CTRL_EXTLO+:3];

    // contact polarity: nc triggers on open, no triggers on close
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            contact_evt <= '0;
        else
            contact_evt <= cont_s ^ incfg_reg;
    end

    // buttons only on connected extensions
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            ext_btn_evt <= '0;
        else
            for (int i = 0; i < NB; i++)
                ext_btn_evt[i] <= btn_s[i] &&
                                  (i / NBTN < int'(ext_cnt));
    end

    // relay: rest closed for nc unless inverse; function flips it
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            relay_close <= '0;
        else
            relay_close <= (rlytype_reg ^ rlyinv_reg)
                           ^ rlydrv_reg;
    end

    // talk state machine
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg    <= MSBR_IDLE;
            tmr_reg   <= '0;
            ptt_q_reg <= 1'b0;
        end
        else
        begin
            ptt_q_reg <= ptt_s;
            case (st_reg)
                MSBR_IDLE:
                    if (ptt_s && !ptt_q_reg)
                    begin
                        tmr_reg <= ctrl_reg[MSBR_CTRL_LOCK] ?
                            TW'(latch_reg) * TW'(CYC_PER_S)
                            : MAX_TALK_CYC;
                        st_reg <= ctrl_reg[MSBR_CTRL_LOCK] ?
                            MSBR_LATCH : MSBR_HELD;
                    end
                // held talk ends on release or the sixty-second limit
                MSBR_HELD:
                begin
                    tmr_reg <= tmr_reg - TW'(1);
                    if (!ptt_s || tmr_reg <= TW'(1))
                        st_reg <= MSBR_IDLE;
                end
                // latched talk ignores the button until time runs out
                MSBR_LATCH:
                begin
                    tmr_reg <= tmr_reg - TW'(1);
                    if (tmr_reg <= TW'(1))
                        st_reg <= MSBR_IDLE;
                end
                default: st_reg <= MSBR_IDLE;
            endcase
        end
    end
    assign talk = (st_reg != MSBR_IDLE);

    // mic source outputs and chimes
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mic_alarm_on <= 1'b0;
            mic_gen_on   <= 1'b0;
            mic_prio     <= '0;
            chime_start  <= 1'b0;
            chime_end    <= 1'b0;
        end
        else
        begin
            // ctrl bit 3 selects the alarm source; general source used otherwise
            mic_alarm_on <= talk && ctrl_reg[3];
            mic_gen_on   <= talk && !ctrl_reg[3];
            mic_prio     <= ctrl_reg[3] ? 9'(prio_a_reg)
                          : MSBR_GEN_BASE + 9'(prio_g_reg);
            chime_start  <= ctrl_reg[MSBR_CTRL_SGONG] && ptt_s
                            && !ptt_q_reg && !talk;
            chime_end    <= ctrl_reg[MSBR_CTRL_EGONG] && !ptt_s
                            && ptt_q_reg;
        end
    end

    // aux inputs off until typed; main mic always on
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aux_mic_en  <= 1'b0;
            aux_line_en <= '0;
            main_mic_en <= 1'b1;
        end
        else
        begin
            aux_mic_en  <= ctrl_reg[MSBR_CTRL_AUXLO];
            aux_line_en <= {4{ctrl_reg[MSBR_CTRL_AUXLO+1]}} &
                           ctrl_reg[15:12];
            main_mic_en <= 1'b1;
        end
    end

    // read mux; unmapped reads zero
    always_comb
    begin
        rdata_next = 16'h0000;
        case (addr)
            MSBR_OFS_CTRL:    rdata_next = ctrl_reg;
            MSBR_OFS_LATCH:   rdata_next = 16'(latch_reg);
            MSBR_OFS_INCFG:   rdata_next = 16'(incfg_reg);
            MSBR_OFS_RLYCFG:  rdata_next = {8'(rlyinv_reg), 8'(rlytype_reg)};
            MSBR_OFS_RLYDRV:  rdata_next = 16'(rlydrv_reg);
            MSBR_OFS_PRIO:    rdata_next = {1'b0, prio_g_reg, 1'b0, prio_a_reg};
            MSBR_OFS_STATUS:  rdata_next = {11'h000, chime_end, chime_start,
                                            ext_cnt[1:0] == 2'b00 ? 1'b0 : 1'b1,
                                            talk, st_reg == MSBR_LATCH};
            MSBR_OFS_INPUTS:  rdata_next = 16'({contact_evt, ptt_s});
            MSBR_OFS_BUTTONS: rdata_next = 16'(ext_btn_evt >>
                                  (int'(extsel_reg) * NBTN));
            MSBR_OFS_EXTSEL:  rdata_next = 16'(extsel_reg);
            default:          rdata_next = 16'h0000;
        endcase
    end

    // read data register; zero when no read strobe
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata     <= '0;
        end
        else
            rdata <= rd ? rdata_next : 16'h0000;
    end

    // latched talk lasts exactly the programmed time
    AST_LATCH_END: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg == MSBR_LATCH && tmr_reg == TW'(1)) |=> st_reg == MSBR_IDLE)
        else $error("latch did not end at timeout");
    AST_LIMIT: assert property (@(posedge ref_clk) disable iff (!resetn)
        talk |-> tmr_reg <= MAX_TALK_CYC)
        else $error("talk timer beyond limit");
    AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg == MSBR_HELD && !ptt_s) |=> st_reg == MSBR_IDLE)
        else $error("momentary talk outlived release");
    AST_CONTACT: assert property (@(posedge ref_clk) disable iff (!resetn)
        ##1 contact_evt == $past(cont_s ^ incfg_reg))
        else $error("contact polarity wrong");
    AST_RELAY: assert property (@(posedge ref_clk) disable iff (!resetn)
        $stable(rlytype_reg ^ rlyinv_reg ^ rlydrv_reg) |=>
        relay_close == $past(rlytype_reg ^ rlyinv_reg ^ rlydrv_reg))
        else $error("relay state wrong");
    AST_CHIME_END: assert property (@(posedge ref_clk) disable iff (!resetn)
        chime_end |-> $past(ptt_q_reg) && !$past(ptt_s) &&
        $past(ctrl_reg[MSBR_CTRL_EGONG]))
        else $error("release chime without release");
    AST_PRIO_A: assert property (@(posedge ref_clk) disable iff (!resetn)
        prio_a_reg <= 7'(MSBR_ALARM_MAX))
        else $error("alarm priority out of range");
    AST_PRIO_G: assert property (@(posedge ref_clk) disable iff (!resetn)
        mic_gen_on |-> mic_prio >= MSBR_GEN_BASE && mic_prio <= MSBR_GEN_MAX)
        else $error("general priority out of range");
    AST_LATCH_CAP: assert property (@(posedge ref_clk) disable iff (!resetn)
        latch_reg <= 6'(MSBR_MAX_TALK_S))
        else $error("latch time above limit");
    AST_EXT: assert property (@(posedge ref_clk) disable iff (!resetn)
        ext_cnt <= 3'(NEXT))
        else $error("too many extensions");
endmodule : msbr_top

// [msbr_pkg.sv]
package msbr_pkg;
    // register offsets (plain port, word index)
    localparam logic [3:0] MSBR_OFS_CTRL    = 4'h0;
    localparam logic [3:0] MSBR_OFS_LATCH   = 4'h1;
    localparam logic [3:0] MSBR_OFS_INCFG   = 4'h2;
    localparam logic [3:0] MSBR_OFS_RLYCFG  = 4'h3;
    localparam logic [3:0] MSBR_OFS_RLYDRV  = 4'h4;
    localparam logic [3:0] MSBR_OFS_PRIO    = 4'h5;
    localparam logic [3:0] MSBR_OFS_STATUS  = 4'h6;
    localparam logic [3:0] MSBR_OFS_INPUTS  = 4'h7;
    localparam logic [3:0] MSBR_OFS_BUTTONS = 4'h8;
    localparam logic [3:0] MSBR_OFS_EXTSEL  = 4'h9;
    // ctrl field positions
    localparam int MSBR_CTRL_LOCK  = 0;
    localparam int MSBR_CTRL_SGONG = 1;
    localparam int MSBR_CTRL_EGONG = 2;
    localparam int MSBR_CTRL_AUXLO = 4;
    localparam int MSBR_CTRL_EXTLO = 8;
    // reset values
    localparam logic [15:0] MSBR_CTRL_RST  = 16'h0000;
    localparam logic [5:0]  MSBR_LATCH_RST = 6'h0A;
    localparam logic [6:0]  MSBR_PRIO_ALARM_RST = 7'h00;
    localparam logic [7:0]  MSBR_PRIO_GEN_RST   = 8'h00;
    // priority classes
    localparam logic [8:0]  MSBR_ALARM_MAX = 9'h063;
    localparam logic [8:0]  MSBR_GEN_BASE  = 9'h0C8;
    localparam logic [8:0]  MSBR_GEN_MAX   = 9'h12B;
    // timing
    localparam int MSBR_CLK_HZ       = 20_000_000;
    localparam int MSBR_MAX_TALK_S   = 60;
    localparam int MSBR_BTN_PER_EXT  = 20;
    localparam int MSBR_MAX_EXT      = 5;
    localparam logic [2:0] MSBR_AUX_OFF  = 3'h0;
endpackage : msbr_pkg

// [msbr_sync_if.sv]
`timescale 1ns/1ps
interface msbr_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src (output raw, input sync);
    modport dst (input raw, output sync);
endinterface : msbr_sync_if

// [msbr_sync.sv]
`timescale 1ns/1ps
module msbr_sync #(
    parameter int W = 8
) (
    input  wire logic ref_clk, // system clock
    input  wire logic resetn,  // async reset, low
    msbr_sync_if.dst  bus      // raw in, synced out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= bus.raw;
            sync_reg <= meta_reg;
        end
    end
    assign bus.sync = sync_reg;
endmodule : msbr_sync

// [msbr_panel.sv]
`timescale 1ns/1ps
// front panel stand-in: talk button, contacts, extension buttons, relays
module msbr_panel
    import msbr_pkg::*;
#(
    parameter int NC = 8,   // contact and relay count
    parameter int NB = 100  // extension button count
) (
    input  wire logic          ptt_press,   // operator holds talk
    input  wire logic [NC-1:0] closed,      // contacts made by the field
    input  wire logic [NB-1:0] press,       // extension buttons held
    input  wire logic [NC-1:0] relay_close, // relay coil command
    output logic               ptt_pin,     // talk pin, high pressed
    output logic      [NC-1:0] contact_pin, // high closed
    output logic      [NB-1:0] ext_btn_pin, // high pressed
    output logic      [NC-1:0] relay_state  // relay contacts seen closed
);
    // clean levels; bounce is left out so timing checks stay exact
    assign ptt_pin     = ptt_press;
    assign contact_pin = closed;
    assign ext_btn_pin = press;
    assign relay_state = relay_close;
endmodule : msbr_panel

// [testbench.sv]
`timescale 1ns/1ps
module testbench
    import msbr_pkg::*;
;
    typedef struct packed {
        logic [7:0]  incfg;
        logic [7:0]  cpin;
        logic [15:0] rcfg;
        logic [7:0]  drv;
        logic [7:0]  evt;
        logic [7:0]  rly;
    } msbr_row_s;
    logic          ref_clk, resetn, wr, rd, ptt, ptt_pin, main_mic_en;
    logic          mic_alarm_on, mic_gen_on, chime_start, chime_end;
    logic          aux_mic_en;
    logic [3:0]    addr, aux_line_en;
    logic [15:0]   wdata, rdata, d;
    logic [7:0]    closed, contact_pin, relay_close, contact_evt;
    logic [99:0]   press, ext_btn_pin, ext_btn_evt;
    logic [8:0]    mic_prio;
    int            error_cnt, compares, n_cs, n_ce, cyc, n, c0;
    msbr_row_s     rows [4];
    // clock at 20 MHz
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ten cycles stand for a second so latch times stay short
    msbr_top #(.CYC_PER_S(10)) i_msbr_top (
        .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ptt_pin(ptt_pin),
        .contact_pin(contact_pin), .ext_btn_pin(ext_btn_pin),
        .relay_close(relay_close), .mic_alarm_on(mic_alarm_on),
        .mic_gen_on(mic_gen_on), .mic_prio(mic_prio),
        .contact_evt(contact_evt), .ext_btn_evt(ext_btn_evt),
        .chime_start(chime_start), .chime_end(chime_end),
        .aux_mic_en(aux_mic_en), .aux_line_en(aux_line_en),
        .main_mic_en(main_mic_en));
    msbr_panel i_msbr_panel (
        .ptt_press(ptt), .closed(closed), .press(press),
        .relay_close(relay_close), .ptt_pin(ptt_pin),
        .contact_pin(contact_pin), .ext_btn_pin(ext_btn_pin),
        .relay_state());
    // chime pulses last one cycle, so count them at every edge
    always @(posedge ref_clk)
    begin
        cyc++;
        if (chime_start === 1'b1) n_cs++;
        if (chime_end === 1'b1) n_ce++;
        if (cyc == 5000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [99:0] e,
                       input logic [99:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    // bounded wait for either talk source to reach a level
    task automatic wait_mic(input logic lvl, output int k);
        k = 0;
        while ((mic_alarm_on | mic_gen_on) !== lvl && k < 1000)
        begin
            @(posedge ref_clk);
            #1 k++;
        end
    endtask : wait_mic
    task automatic talk(input int hold);
        @(posedge ref_clk);
        ptt <= 1'b1;
        wait_mic(1'b1, n);
        repeat (hold) @(posedge ref_clk);
        ptt <= 1'b0;
        #1;
    endtask : talk
    task automatic wrap_up();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial
    begin
        {resetn, wr, rd, ptt, addr, wdata, closed, press} = '0;
        rows[0] = '{8'h00, 8'h00, 16'h00FF, 8'h00, 8'h00, 8'hFF};
        rows[1] = '{8'hFF, 8'hFF, 16'h00FF, 8'h0F, 8'h00, 8'hF0};
        rows[2] = '{8'hFF, 8'h0F, 16'hFFFF, 8'h00, 8'hF0, 8'h00};
        rows[3] = '{8'h0F, 8'hF0, 16'hFFFF, 8'h0F, 8'hFF, 8'h0F};
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        #1 chk("main_mic_en", 1, main_mic_en);
        chk("aux_mic_en", 0, aux_mic_en);
        rd_reg(MSBR_OFS_PRIO, d);
        chk("prio reset", 16'h0000, d);
        wr_reg(4'hF, 16'hFFFF);
        rd_reg(4'hF, d);
        chk("unmapped", 16'h0000, d);
        rd_reg(MSBR_OFS_CTRL, d);
        chk("ctrl", 16'h0000, d);
        // contact polarity and relay type against drive
        foreach (rows[i])
        begin
            wr_reg(MSBR_OFS_INCFG, {8'h00, rows[i].incfg});
            wr_reg(MSBR_OFS_RLYCFG, rows[i].rcfg);
            wr_reg(MSBR_OFS_RLYDRV, {8'h00, rows[i].drv});
            closed <= rows[i].cpin;
            repeat (5) @(posedge ref_clk);
            #1 chk("contact_evt", rows[i].evt, contact_evt);
            chk("relay_close", rows[i].rly, relay_close);
        end
        rd_reg(MSBR_OFS_INPUTS, d);
        chk("inputs", 16'h01FE, d);
        // alarm source, momentary, both chimes on
        wr_reg(MSBR_OFS_PRIO, 16'h0563);
        wr_reg(MSBR_OFS_CTRL, 16'h000E);
        c0 = n_cs;
        talk(4);
        chk("alarm on", 1, mic_alarm_on);
        chk("alarm prio", 9'd99, mic_prio);
        chk("start chime", 1, n_cs - c0);
        c0 = n_ce;
        wait_mic(1'b0, n);
        chk("momentary end", 1, n >= 3 && n <= 5);
        repeat (5) @(posedge ref_clk);
        chk("end chime", 1, n_ce - c0);
        // general source, chimes off
        wr_reg(MSBR_OFS_CTRL, 16'h0000);
        c0 = n_cs + n_ce;
        talk(2);
        chk("gen on", 1, mic_gen_on);
        chk("gen prio", 9'd205, mic_prio);
        wait_mic(1'b0, n);
        repeat (5) @(posedge ref_clk);
        chk("no chime", 0, n_cs + n_ce - c0);
        wr_reg(MSBR_OFS_PRIO, 16'h7F78);
        rd_reg(MSBR_OFS_PRIO, d);
        chk("prio clamp", 16'h6363, d);
        // latched talk outlives a short press
        wr_reg(MSBR_OFS_LATCH, 16'h0003);
        wr_reg(MSBR_OFS_CTRL, 16'h0009);
        talk(2);
        rd_reg(MSBR_OFS_STATUS, d);
        chk("status", 16'h0003, d);
        wait_mic(1'b0, n);
        chk("latch time", 1, n >= 25 && n <= 31);
        wr_reg(MSBR_OFS_LATCH, 16'h0046);
        rd_reg(MSBR_OFS_LATCH, d);
        chk("latch clamp", 16'h003C, d);
        // held button is cut off after sixty seconds
        wr_reg(MSBR_OFS_CTRL, 16'h0008);
        @(posedge ref_clk);
        ptt <= 1'b1;
        wait_mic(1'b1, n);
        wait_mic(1'b0, n);
        chk("talk limit", 1, n >= 594 && n <= 602);
        @(posedge ref_clk);
        ptt   <= 1'b0;
        press <= '1;
        wr_reg(MSBR_OFS_CTRL, 16'h0200);
        repeat (5) @(posedge ref_clk);
        #1 chk("two ext", {60'h0, {40{1'b1}}}, ext_btn_evt);
        wr_reg(MSBR_OFS_EXTSEL, 16'h0002);
        rd_reg(MSBR_OFS_EXTSEL, d);
        chk("extsel", 16'h0002, d);
        rd_reg(MSBR_OFS_BUTTONS, d);
        chk("ext2 buttons", 16'h0000, d);
        wr_reg(MSBR_OFS_CTRL, 16'hA730);
        repeat (5) @(posedge ref_clk);
        #1 chk("ext cap", {100{1'b1}}, ext_btn_evt);
        rd_reg(MSBR_OFS_BUTTONS, d);
        chk("ext5 buttons", 16'hFFFF, d);
        chk("aux mic", 1, aux_mic_en);
        chk("aux line", 4'hA, aux_line_en);
        // reset in mid-run restores defaults
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_reg(MSBR_OFS_LATCH, d);
        chk("latch reset", 16'h000A, d);
        chk("ext off", 100'h0, ext_btn_evt);
        chk("aux off", 0, aux_mic_en);
        chk("main mic", 1, main_mic_en);
        chk("relay reset", 8'h00, relay_close);
        wrap_up();
    end
endmodule : testbench
